// ---- src/capture_sync_pkg.sv ----
package capture_sync_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int CG_W = 10;
  localparam int OCTET_W = 8;
  localparam int SAMPLE_OCTETS = 2;
  localparam int SAMPLE_W = OCTET_W * SAMPLE_OCTETS;
  localparam int MEM_ADDR_W = 10;
  localparam int LMFC_CNT_W = 8;

  // ----------------------------------------------------------------
  // defaults and codes
  // ----------------------------------------------------------------
  localparam logic [LMFC_CNT_W-1:0] LMFC_DIV_DEF = 8'h10;
  localparam logic [MEM_ADDR_W:0] CAPTURE_LEN_DEF = 11'h400;
  localparam logic [1:0] SUBCLASS_1 = 2'h1;
  localparam logic [1:0] SUBCLASS_2 = 2'h2;

  // synchronised pin bit positions
  localparam int PIN_SYSREF = 0;
  localparam int PIN_SYNC = 1;
  localparam int PIN_TRIG_EXT = 2;
  localparam int PIN_TRIG_IN = 3;
  localparam int PIN_N = 4;

  // 6b group of the only control character family decoded
  localparam logic [5:0] K28_NEG = 6'h0f;
  localparam logic [5:0] K28_POS = 6'h30;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic is_ctrl;
    logic err;
    logic [OCTET_W-1:0] octet;
  } octet_t;

  typedef struct packed {
    logic en;
    logic [MEM_ADDR_W-1:0] addr;
    logic [SAMPLE_W-1:0] data;
  } mem_wr_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ARMED = 4'h2,
    ST_CAPTURE = 4'h4,
    ST_DONE = 4'h8
  } cap_state_t;

endpackage

// ---- src/code_group_decoder.sv ----
`timescale 1ns/100ps
module code_group_decoder (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [capture_sync_pkg::CG_W-1:0] code_group,
  input wire logic code_valid,
  output capture_sync_pkg::octet_t octet_out
);

  logic [5:0] six_b;
  logic [3:0] four_b;
  logic [4:0] low5;
  logic [2:0] high3;
  logic bad6;
  logic bad4;
  logic is_k;

  assign six_b = code_group[9:4];

  // ----------------------------------------------------------------
  // 6b to 5b
  // ----------------------------------------------------------------
  always_comb begin
    low5 = 5'h00;
    bad6 = 1'b0;
    is_k = 1'b0;
    unique case (six_b)
      6'h27, 6'h18: low5 = 5'h00;
      6'h1d, 6'h22: low5 = 5'h01;
      6'h2d, 6'h12: low5 = 5'h02;
      6'h31: low5 = 5'h03;
      6'h35, 6'h0a: low5 = 5'h04;
      6'h29: low5 = 5'h05;
      6'h19: low5 = 5'h06;
      6'h38, 6'h07: low5 = 5'h07;
      6'h39, 6'h06: low5 = 5'h08;
      6'h25: low5 = 5'h09;
      6'h15: low5 = 5'h0a;
      6'h34: low5 = 5'h0b;
      6'h0d: low5 = 5'h0c;
      6'h2c: low5 = 5'h0d;
      6'h1c: low5 = 5'h0e;
      6'h17, 6'h28: low5 = 5'h0f;
      6'h1b, 6'h24: low5 = 5'h10;
      6'h23: low5 = 5'h11;
      6'h13: low5 = 5'h12;
      6'h32: low5 = 5'h13;
      6'h0b: low5 = 5'h14;
      6'h2a: low5 = 5'h15;
      6'h1a: low5 = 5'h16;
      6'h3a, 6'h05: low5 = 5'h17;
      6'h33, 6'h0c: low5 = 5'h18;
      6'h26: low5 = 5'h19;
      6'h16: low5 = 5'h1a;
      6'h36, 6'h09: low5 = 5'h1b;
      6'h0e: low5 = 5'h1c;
      6'h2e, 6'h11: low5 = 5'h1d;
      6'h1e, 6'h21: low5 = 5'h1e;
      6'h2b, 6'h14: low5 = 5'h1f;
      capture_sync_pkg::K28_NEG, capture_sync_pkg::K28_POS: begin
        low5 = 5'h1c;
        is_k = 1'b1;
      end
      default: bad6 = 1'b1;
    endcase
  end

  // positive-disparity control groups carry an inverted 4b tail
  assign four_b = (six_b == capture_sync_pkg::K28_POS) ? ~code_group[3:0] : code_group[3:0];

  // ----------------------------------------------------------------
  // 4b to 3b
  // ----------------------------------------------------------------
  always_comb begin
    high3 = 3'h0;
    bad4 = 1'b0;
    unique case (four_b)
      4'hb, 4'h4: high3 = 3'h0;
      4'h9: high3 = 3'h1;
      4'h5: high3 = 3'h2;
      4'hc, 4'h3: high3 = 3'h3;
      4'hd, 4'h2: high3 = 3'h4;
      4'ha: high3 = 3'h5;
      4'h6: high3 = 3'h6;
      4'he, 4'h1, 4'h7, 4'h8: high3 = 3'h7;
      default: bad4 = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // registered octet
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      octet_out <= '0;
    end else if (ce) begin
      octet_out.valid <= code_valid;
      octet_out.is_ctrl <= is_k;
      octet_out.err <= code_valid & (bad6 | bad4);
      octet_out.octet <= {high3, low5};
    end
  end

endmodule // code_group_decoder

// ---- src/capture_sync.sv ----
`timescale 1ns/100ps
// Behaviour
// - The master registers its external or software trigger at each SYSREF/LMFC rising edge to form trigger-out.
// - The master uses its trigger-out as its own capture enable and drives it out to the slaves.
// - Master and slave start writing samples to memory only at an LMFC edge where trigger-out is high.
// - All sampling, frame, character and bit timing comes from the one shared device clock.
// - A shared reference resets the multiframe divider phase: SYSREF for subclass 1, SYNC for subclass 2.
// - Samples travel as 8-bit octets and the receiver packs octets back into samples.
// - Each octet travels as a 10-bit code group which the receiver decodes back to an octet.
// - The transmitter inserts control characters and the receiver removes them before sample extraction.
module capture_sync #(
  parameter logic [capture_sync_pkg::LMFC_CNT_W-1:0] LMFC_DIV = capture_sync_pkg::LMFC_DIV_DEF,
  parameter logic [capture_sync_pkg::MEM_ADDR_W:0] CAPTURE_LEN = capture_sync_pkg::CAPTURE_LEN_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic is_master,
  input wire logic [1:0] subclass,
  input wire logic trig_sw,
  input wire logic capture_arm,
  input wire logic sysref_pin,
  input wire logic sync_pin,
  input wire logic trig_ext_pin,
  input wire logic trig_in_pin,
  input wire logic [capture_sync_pkg::CG_W-1:0] code_group,
  input wire logic code_valid,
  output logic trig_out_pin,
  output logic lmfc_tick,
  output capture_sync_pkg::mem_wr_t mem_wr,
  output logic capture_busy,
  output logic capture_done,
  output logic decode_err
);

  localparam int PN = capture_sync_pkg::PIN_N;
  localparam int SO = capture_sync_pkg::SAMPLE_OCTETS;
  localparam int OW = capture_sync_pkg::OCTET_W;

  logic [PN-1:0] pins_raw;
  logic [PN-1:0] meta_reg;
  logic [PN-1:0] sync_reg;
  logic [PN-1:0] prev_reg;
  logic ref_rise;
  logic [capture_sync_pkg::LMFC_CNT_W-1:0] lmfc_cnt_reg;
  logic lmfc_edge;
  logic trig_src;
  logic trig_out_reg;
  logic cap_enable;
  capture_sync_pkg::cap_state_t state_reg;
  capture_sync_pkg::cap_state_t state_next;
  logic [capture_sync_pkg::MEM_ADDR_W:0] wr_count_reg;
  capture_sync_pkg::octet_t oct;
  logic [capture_sync_pkg::SAMPLE_W-1:0] pack_reg;
  logic [$clog2(SO+1)-1:0] pack_cnt_reg;
  logic sample_ready_reg;
  logic [capture_sync_pkg::SAMPLE_W-1:0] sample_reg;

  assign pins_raw = {trig_in_pin, trig_ext_pin, sync_pin, sysref_pin};

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PN; gi++) begin : g_sync
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
          prev_reg[gi] <= 1'b0;
        end else if (ce) begin
          meta_reg[gi] <= pins_raw[gi];
          sync_reg[gi] <= meta_reg[gi];
          prev_reg[gi] <= sync_reg[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // multiframe divider and phase reference
  // ----------------------------------------------------------------
  always_comb begin
    ref_rise = 1'b0;
    if (subclass == capture_sync_pkg::SUBCLASS_2) begin
      ref_rise = sync_reg[capture_sync_pkg::PIN_SYNC] & ~prev_reg[capture_sync_pkg::PIN_SYNC];
    end else if (subclass == capture_sync_pkg::SUBCLASS_1) begin
      ref_rise = sync_reg[capture_sync_pkg::PIN_SYSREF] & ~prev_reg[capture_sync_pkg::PIN_SYSREF];
    end
  end

  // divider runs on the one device clock, no private timebase
  assign lmfc_edge = ref_rise | (lmfc_cnt_reg == LMFC_DIV - 1'b1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lmfc_cnt_reg <= '0;
    end else if (ce) begin
      if (lmfc_edge) begin
        lmfc_cnt_reg <= '0;
      end else begin
        lmfc_cnt_reg <= lmfc_cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lmfc_tick <= 1'b0;
    end else if (ce) begin
      lmfc_tick <= lmfc_edge;
    end
  end

  // ----------------------------------------------------------------
  // trigger-out generation
  // ----------------------------------------------------------------
  assign trig_src = sync_reg[capture_sync_pkg::PIN_TRIG_EXT] | trig_sw;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_out_reg <= 1'b0;
    end else if (ce && lmfc_edge) begin
      trig_out_reg <= is_master & trig_src;
    end
  end

  // slaves stay low on the forwarded line
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      trig_out_pin <= 1'b0;
    end else if (ce) begin
      trig_out_pin <= is_master & trig_out_reg;
    end
  end

  // master follows its own trigger-out, slave the forwarded one
  assign cap_enable = is_master ? trig_out_reg : sync_reg[capture_sync_pkg::PIN_TRIG_IN];

  // ----------------------------------------------------------------
  // capture sequencing
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      capture_sync_pkg::ST_IDLE: begin
        if (capture_arm) begin
          state_next = capture_sync_pkg::ST_ARMED;
        end
      end
      capture_sync_pkg::ST_ARMED: begin
        // low enable at the edge leaves the block waiting
        if (lmfc_edge && cap_enable) begin
          state_next = capture_sync_pkg::ST_CAPTURE;
        end
      end
      capture_sync_pkg::ST_CAPTURE: begin
        if (sample_ready_reg && (wr_count_reg == CAPTURE_LEN - 1'b1)) begin
          state_next = capture_sync_pkg::ST_DONE;
        end
      end
      capture_sync_pkg::ST_DONE: begin
        if (capture_arm) begin
          state_next = capture_sync_pkg::ST_ARMED;
        end
      end
      default: state_next = capture_sync_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= capture_sync_pkg::ST_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      capture_busy <= 1'b0;
      capture_done <= 1'b0;
    end else if (ce) begin
      capture_busy <= (state_next == capture_sync_pkg::ST_CAPTURE);
      capture_done <= (state_next == capture_sync_pkg::ST_DONE);
    end
  end

  // ----------------------------------------------------------------
  // receive path: decode, drop control, pack
  // ----------------------------------------------------------------
  code_group_decoder u_decoder (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .code_group(code_group),
    .code_valid(code_valid),
    .octet_out(oct)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      decode_err <= 1'b0;
    end else if (ce) begin
      decode_err <= oct.err;
    end
  end

  // first octet of a sample is its most significant
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pack_reg <= '0;
      pack_cnt_reg <= '0;
      sample_ready_reg <= 1'b0;
      sample_reg <= '0;
    end else if (ce) begin
      sample_ready_reg <= 1'b0;
      if (oct.valid && !oct.is_ctrl && !oct.err) begin
        pack_reg <= {pack_reg[capture_sync_pkg::SAMPLE_W-OW-1:0], oct.octet};
        if (pack_cnt_reg == SO - 1) begin
          pack_cnt_reg <= '0;
          sample_ready_reg <= 1'b1;
          sample_reg <= {pack_reg[capture_sync_pkg::SAMPLE_W-OW-1:0], oct.octet};
        end else begin
          pack_cnt_reg <= pack_cnt_reg + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // memory write port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mem_wr <= '0;
      wr_count_reg <= '0;
    end else if (ce) begin
      mem_wr.en <= 1'b0;
      if (state_reg == capture_sync_pkg::ST_ARMED) begin
        wr_count_reg <= '0;
      end else if (state_reg == capture_sync_pkg::ST_CAPTURE && sample_ready_reg) begin
        mem_wr.en <= 1'b1;
        mem_wr.addr <= wr_count_reg[capture_sync_pkg::MEM_ADDR_W-1:0];
        mem_wr.data <= sample_reg;
        wr_count_reg <= wr_count_reg + 1'b1;
      end
    end
  end

endmodule // capture_sync

// ---- sim/adc_tx_model.sv ----
`timescale 1ns/100ps
// sends samples 0x0001 and 0x0203 with a comma between them
module adc_tx_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic gap,
  input wire logic bad,
  output logic [capture_sync_pkg::CG_W-1:0] code_group,
  output logic code_valid
);
  logic [2:0] idx_reg;
  logic slot_reg;
  logic [capture_sync_pkg::CG_W-1:0] cg;
  always_comb begin
    case (idx_reg)
      3'h0: cg = 10'h274;
      3'h1: cg = 10'h1d4;
      3'h2: cg = 10'h0fa;
      3'h3: cg = 10'h2d4;
      default: cg = 10'h31b;
    endcase
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idx_reg <= 3'h0;
      slot_reg <= 1'b0;
      code_valid <= 1'b0;
      code_group <= 10'h155;
    end else if (gap && slot_reg) begin
      slot_reg <= 1'b0;
      code_valid <= 1'b0;
      code_group <= ~code_group;
    end else begin
      slot_reg <= 1'b1;
      code_valid <= 1'b1;
      code_group <= bad ? 10'h000 : cg;
      if (!bad) idx_reg <= idx_reg == 3'h4 ? 3'h0 : idx_reg + 3'h1;
    end
  end
endmodule // adc_tx_model

// ---- sim/capture_sync_assertions.sv ----
`timescale 1ns/100ps
module capture_sync_checker #(
  parameter logic [capture_sync_pkg::LMFC_CNT_W-1:0] LMFC_DIV = capture_sync_pkg::LMFC_DIV_DEF,
  parameter logic [capture_sync_pkg::MEM_ADDR_W:0] CAPTURE_LEN = capture_sync_pkg::CAPTURE_LEN_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic is_master,
  input wire logic [1:0] subclass,
  input wire logic sysref_pin,
  input wire logic sync_pin,
  input wire logic trig_out_pin,
  input wire logic lmfc_tick,
  input wire capture_sync_pkg::mem_wr_t mem_wr,
  input wire logic capture_busy,
  input wire logic capture_done
);
  localparam int DIV = int'(LMFC_DIV);
  logic [capture_sync_pkg::MEM_ADDR_W:0] wr_cnt_reg;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // writes seen in the current burst
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_cnt_reg <= '0;
    end else if (mem_wr.en) begin
      wr_cnt_reg <= wr_cnt_reg + 1'b1;
    end else if (!capture_busy) begin
      wr_cnt_reg <= '0;
    end
  end
  AST_TRIG_EDGE: assert property ($changed(trig_out_pin) |-> $past(lmfc_tick))
    else $error("trigger-out moved off an lmfc edge");
  AST_TRIG_MASTER: assert property ($rose(trig_out_pin) |-> $past(is_master, 2))
    else $error("trigger-out raised by a slave");
  AST_START_TICK: assert property ($rose(capture_busy) |-> lmfc_tick)
    else $error("capture began off an lmfc edge");
  AST_ADDR_SEQ: assert property (
    mem_wr.en |-> mem_wr.addr == wr_cnt_reg[capture_sync_pkg::MEM_ADDR_W-1:0])
    else $error("write address out of order");
  AST_BURST_LEN: assert property ($rose(capture_done) |-> wr_cnt_reg + mem_wr.en == CAPTURE_LEN)
    else $error("burst length wrong");
  AST_NO_STORE: assert property (mem_wr.en |-> capture_busy || $past(capture_busy))
    else $error("write outside a capture");
  AST_TICK_PERIOD: assert property (lmfc_tick |-> ##[1:DIV] lmfc_tick)
    else $error("lmfc period too long");
  AST_SYSREF_ALIGN: assert property (
    subclass == capture_sync_pkg::SUBCLASS_1 && $rose(sysref_pin) |-> ##[2:4] lmfc_tick)
    else $error("no realign on sysref");
  AST_SYNC_ALIGN: assert property (
    subclass == capture_sync_pkg::SUBCLASS_2 && $rose(sync_pin) |-> ##[2:4] lmfc_tick)
    else $error("no realign on sync");
endmodule // capture_sync_checker
bind capture_sync capture_sync_checker #(.LMFC_DIV(LMFC_DIV), .CAPTURE_LEN(CAPTURE_LEN)) chk_i (
  .clk_sys, .rst, .is_master, .subclass, .sysref_pin, .sync_pin, .trig_out_pin, .lmfc_tick, .mem_wr,
  .capture_busy, .capture_done
);

// ---- sim/tb_multi_receiver_capture_sync.sv ----
`timescale 1ns/100ps
module tb_multi_receiver_capture_sync;
  localparam int DIV = 8;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic is_master = 1'b1;
  logic [1:0] subclass = 2'h1;
  logic trig_sw = 1'b0;
  logic capture_arm = 1'b0;
  logic sysref_pin = 1'b0;
  logic sync_pin = 1'b0;
  logic trig_ext_pin = 1'b0;
  logic trig_in_pin = 1'b0;
  logic gap = 1'b0;
  logic bad = 1'b0;
  logic [capture_sync_pkg::CG_W-1:0] code_group;
  logic code_valid, trig_out_pin, lmfc_tick, capture_busy, capture_done, decode_err;
  capture_sync_pkg::mem_wr_t mem_wr;
  int errors = 0;
  int tests_run = 0;
  always #5 clk_sys = ~clk_sys;
  adc_tx_model tx (.clk_sys, .rst, .gap, .bad, .code_group, .code_valid);
  capture_sync #(.LMFC_DIV(8'h08), .CAPTURE_LEN(11'h004)) dut (
    .clk_sys, .rst, .ce(1'b1), .is_master, .subclass, .trig_sw, .capture_arm, .sysref_pin, .sync_pin,
    .trig_ext_pin, .trig_in_pin, .code_group, .code_valid, .trig_out_pin, .lmfc_tick, .mem_wr,
    .capture_busy, .capture_done, .decode_err
  );
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic tick(output int n);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (lmfc_tick !== 1'b1 && n < 40);
  endtask
  task automatic arm();
    @(posedge clk_sys) capture_arm <= 1'b1;
    @(posedge clk_sys) capture_arm <= 1'b0;
  endtask
  // nothing stored or started for three multiframes
  task automatic quiet();
    int w;
    w = 0;
    repeat (3 * DIV) begin
      cyc(1);
      if (mem_wr.en !== 1'b0 || capture_busy !== 1'b0) w++;
    end
    chk(16'(w), 16'h0000);
  endtask
  // pulse one reference just after a tick, measure the next two ticks
  task automatic ref_chk(input logic on_sync, input int lo, input int hi);
    int n;
    tick(n);
    @(posedge clk_sys) begin
      sysref_pin <= !on_sync;
      sync_pin <= on_sync;
    end
    n = 0;
    do begin
      @(posedge clk_sys);
      if (n == 1) begin
        sysref_pin <= 1'b0;
        sync_pin <= 1'b0;
      end
      #1 n++;
    end while (lmfc_tick !== 1'b1 && n < 40);
    chk(16'(n >= lo && n <= hi), 16'h0001);
    tick(n);
    chk(16'(n), 16'(DIV));
  endtask
  task automatic capture(input logic exp_pin);
    int n;
    logic [15:0] last;
    n = 0;
    last = 16'h0000;
    arm();
    cyc(1);
    for (int i = 0; i < 200 && capture_done !== 1'b1; i++) begin
      cyc(1);
      if (mem_wr.en === 1'b1) begin
        chk(16'(mem_wr.addr), 16'(n));
        if (n == 0) chk(mem_wr.data & 16'hfdfd, 16'h0001);
        else chk(mem_wr.data, last ^ 16'h0202);
        last = mem_wr.data;
        n++;
      end
    end
    chk(16'(n), 16'h0004);
    chk(16'({capture_busy, capture_done, trig_out_pin}), 16'({2'b01, exp_pin}));
  endtask
  task automatic summarize();
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    int n;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(1);
    chk(16'({trig_out_pin, mem_wr.en, capture_busy, capture_done}), 16'h0000);
    ref_chk(1'b0, 2, 4);
    ref_chk(1'b1, DIV - 1, DIV - 1);
    arm();
    quiet();
    @(posedge clk_sys) trig_sw <= 1'b1;
    capture(1'b1);
    quiet();
    chk(16'(trig_out_pin), 16'h0001);
    @(posedge clk_sys) begin
      subclass <= 2'h2;
      trig_sw <= 1'b0;
      trig_ext_pin <= 1'b1;
      gap <= 1'b1;
    end
    ref_chk(1'b1, 2, 4);
    ref_chk(1'b0, DIV - 1, DIV - 1);
    @(posedge clk_sys) bad <= 1'b1;
    repeat (2) @(posedge clk_sys);
    bad <= 1'b0;
    n = 0;
    repeat (6) begin
      cyc(1);
      if (decode_err === 1'b1) n++;
    end
    chk(16'(n > 0), 16'h0001);
    capture(1'b1);
    @(posedge clk_sys) begin
      trig_ext_pin <= 1'b0;
      gap <= 1'b0;
    end
    // let trigger-out fall on an lmfc edge before becoming a slave
    tick(n);
    tick(n);
    @(posedge clk_sys) begin
      is_master <= 1'b0;
      subclass <= 2'h0;
    end
    ref_chk(1'b0, DIV - 1, DIV - 1);
    arm();
    quiet();
    @(posedge clk_sys) trig_in_pin <= 1'b1;
    capture(1'b0);
    quiet();
    summarize();
  end
  initial begin
    #100000;
    errors++;
    summarize();
  end
endmodule // tb_multi_receiver_capture_sync
